/* cfsc_pkg.sv */
// Constants shared by the front-end serial control register bank.
package cfsc_pkg;

    // ****************************************************************
    // Frame layout
    // ****************************************************************
    localparam int ADDR_W = 3;
    localparam int DATA_W = 10;
    localparam int FRAME_BITS = ADDR_W + DATA_W;
    localparam logic [3:0] FRAME_BITS_CNT = 4'hd;
    localparam logic [3:0] CNT_MAX = 4'hf;
    localparam int ADDR_LSB = DATA_W;

    // ****************************************************************
    // Word addresses
    // ****************************************************************
    localparam logic [2:0] ADDR_AUX_DAC = 3'h0;
    localparam logic [2:0] ADDR_SOFT_CLIP = 3'h1;
    localparam logic [2:0] ADDR_GAIN = 3'h2;
    localparam logic [2:0] ADDR_STANDBY = 3'h3;
    localparam logic [2:0] ADDR_CLAMP_REF = 3'h4;

    // ****************************************************************
    // Field widths and positions
    // ****************************************************************
    localparam int AUX_DAC_W = 8;
    localparam int SOFT_CLIP_W = 4;
    localparam int GAIN_W = 9;
    localparam int STANDBY_W = 4;
    localparam int CLAMP_REF_W = 10;
    localparam int STBY_CDS_AGC_CLIP_BIT = 0;
    localparam int STBY_CLAMP_BLANK_BIT = 1;
    localparam int STBY_AUX_DAC_BIT = 2;
    localparam int STBY_FIXED_AMP_BIT = 3;

    // Codes at or above this all give maximum gain
    localparam logic [8:0] GAIN_SAT_CODE = 9'h13f;

    // ****************************************************************
    // Values after reset
    // ****************************************************************
    localparam logic [7:0] RST_AUX_DAC = 8'h00;
    localparam logic [3:0] RST_SOFT_CLIP = 4'h0;
    localparam logic [8:0] RST_GAIN = 9'h000;
    localparam logic [3:0] RST_STANDBY = 4'h0;
    localparam logic [9:0] RST_CLAMP_REF = 10'h000;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int SYS_CLK_HZ = 40_000_000;
    localparam int SCLK_MAX_HZ = 5_000_000;
    // Fewest system cycles per serial clock period at the fastest rate
    localparam int SCLK_MIN_CYC = SYS_CLK_HZ / SCLK_MAX_HZ;
    localparam int SYNC_STAGES = 2;

endpackage

/* cfsc_sync.sv */
// Two-flop synchroniser for a group of pin inputs.
module cfsc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_sync;

    always_comb begin
        next_meta = async_i;
        next_sync = meta;
    end

    // First stage feeds only the second stage
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            meta <= '0;
            sync_o <= '0;
        end else begin
            meta <= next_meta;
            sync_o <= next_sync;
        end
    end
endmodule // cfsc_sync

/* cfsc_regs.sv */
// Serially loaded control word bank of the camera front end.
//
// What this block does
// [RULE1] Address 0 loads the 8-bit auxiliary control DAC code from data bits 7..0.
// [RULE2] Address 1 loads the 4-bit soft clipper setting; upper six bits ignored.
// [RULE3] Address 2 loads the 9-bit gain code from data bits 8..0.
// [RULE4] Address 3 loads four standby bits; upper six bits ignored.
// [RULE5] Standby bit 0 set puts sampling, gain and clipper stages in standby.
// [RULE6] Standby bit 1 set puts black clamp and blanking stage in standby.
// [RULE7] Standby bit 2 set puts the auxiliary control DAC in standby.
// [RULE8] Standby bit 3 set puts the fixed 6 dB output amplifier in standby.
// [RULE9] Address 4 loads the full 10-bit clamp reference DAC code.
// [RULE10] Clamp reference code tunes converter clamp level in half-LSB steps.
// [RULE11] Serial clock runs at most 5 MHz.
// [RULE12] Gain code zero is minimum gain; codes 319 and above saturate at maximum.
// [RULE13] Frame is 3 address then 10 data bits; word updates when enable ends.
module cfsc_regs (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic sclk_i,
    input wire logic sen_i,
    input wire logic sdata_i,
    output logic [cfsc_pkg::AUX_DAC_W-1:0] aux_control_dac_o,
    output logic [cfsc_pkg::SOFT_CLIP_W-1:0] soft_clip_setting_o,
    output logic [cfsc_pkg::GAIN_W-1:0] gain_code_o,
    output logic [cfsc_pkg::GAIN_W-1:0] gain_applied_o,
    output logic stby_cds_agc_clip_o,
    output logic stby_clamp_blank_o,
    output logic stby_aux_dac_o,
    output logic stby_fixed_amp_o,
    output logic [cfsc_pkg::CLAMP_REF_W-1:0] clamp_ref_dac_code_o
);
    import cfsc_pkg::*;

    // ****************************************************************
    // Pin synchronisation and edge detection
    // ****************************************************************
    logic [2:0] pins_sync;
    logic sclk_s;
    logic sen_s;
    logic sdata_s;
    logic sclk_d;
    logic sen_d;
    logic sclk_rise;
    logic frame_end;

    cfsc_sync #(
        .WIDTH(3)
    ) u_sync (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .async_i({sclk_i, sen_i, sdata_i}),
        .sync_o(pins_sync)
    );

    assign sclk_s = pins_sync[2];
    assign sen_s = pins_sync[1];
    assign sdata_s = pins_sync[0];
    // All three pins see the same delay, so data stays aligned to its clock edge.
    // At 5 MHz an edge is 8 system cycles apart, ample for this sampling.
    assign sclk_rise = sclk_s && !sclk_d; // RULE11
    assign frame_end = sen_d && !sen_s; // RULE13

    // ****************************************************************
    // Shift register and bit counter
    // ****************************************************************
    logic [FRAME_BITS-1:0] shreg;
    logic [FRAME_BITS-1:0] next_shreg;
    logic [3:0] bit_cnt;
    logic [3:0] next_bit_cnt;
    logic next_sclk_d;
    logic next_sen_d;

    always_comb begin
        next_sclk_d = sclk_s;
        next_sen_d = sen_s;
        next_shreg = shreg;
        next_bit_cnt = bit_cnt;
        if (!sen_s) begin
            next_bit_cnt = 4'h0;
        end else if (sclk_rise) begin
            // MSB first: address bits then data bits
            next_shreg = {shreg[FRAME_BITS-2:0], sdata_s}; // RULE13
            if (bit_cnt != CNT_MAX) begin
                next_bit_cnt = bit_cnt + 4'h1;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            sclk_d <= 1'b0;
            sen_d <= 1'b0;
            shreg <= '0;
            bit_cnt <= 4'h0;
        end else begin
            sclk_d <= next_sclk_d;
            sen_d <= next_sen_d;
            shreg <= next_shreg;
            bit_cnt <= next_bit_cnt;
        end
    end

    // ****************************************************************
    // Word decode and update
    // ****************************************************************
    logic wr_en;
    logic [ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_data;

    // A frame with the wrong bit count is dropped rather than half-applied
    assign wr_en = frame_end && (bit_cnt == FRAME_BITS_CNT); // RULE13
    assign wr_addr = shreg[FRAME_BITS-1:ADDR_LSB];
    assign wr_data = shreg[DATA_W-1:0];

    function automatic logic [GAIN_W-1:0] gain_clamp(input logic [GAIN_W-1:0] code);
        gain_clamp = (code >= GAIN_SAT_CODE) ? GAIN_SAT_CODE : code;
    endfunction

    logic [AUX_DAC_W-1:0] next_aux;
    logic [SOFT_CLIP_W-1:0] next_clip;
    logic [GAIN_W-1:0] next_gain;
    logic [GAIN_W-1:0] next_gain_applied;
    logic [STANDBY_W-1:0] standby;
    logic [STANDBY_W-1:0] next_standby;
    logic [CLAMP_REF_W-1:0] next_clamp;

    always_comb begin
        next_aux = aux_control_dac_o;
        next_clip = soft_clip_setting_o;
        next_gain = gain_code_o;
        next_gain_applied = gain_applied_o;
        next_standby = standby;
        next_clamp = clamp_ref_dac_code_o;
        if (wr_en) begin
            unique case (wr_addr)
                ADDR_AUX_DAC: begin
                    next_aux = wr_data[AUX_DAC_W-1:0]; // RULE1
                end
                ADDR_SOFT_CLIP: begin
                    next_clip = wr_data[SOFT_CLIP_W-1:0]; // RULE2
                end
                ADDR_GAIN: begin
                    next_gain = wr_data[GAIN_W-1:0]; // RULE3
                    next_gain_applied = gain_clamp(wr_data[GAIN_W-1:0]); // RULE12
                end
                ADDR_STANDBY: begin
                    next_standby = wr_data[STANDBY_W-1:0]; // RULE4
                end
                ADDR_CLAMP_REF: begin
                    // Steps of half a converter LSB across the lower half of its range
                    next_clamp = wr_data; // RULE9 RULE10
                end
                default: begin
                    // Addresses 5 to 7 name no word and are ignored
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            aux_control_dac_o <= RST_AUX_DAC;
            soft_clip_setting_o <= RST_SOFT_CLIP;
            gain_code_o <= RST_GAIN;
            gain_applied_o <= RST_GAIN;
            standby <= RST_STANDBY;
            clamp_ref_dac_code_o <= RST_CLAMP_REF;
        end else begin
            aux_control_dac_o <= next_aux;
            soft_clip_setting_o <= next_clip;
            gain_code_o <= next_gain;
            gain_applied_o <= next_gain_applied;
            standby <= next_standby;
            clamp_ref_dac_code_o <= next_clamp;
        end
    end

    // ****************************************************************
    // Standby controls to the analog stages
    // ****************************************************************
    assign stby_cds_agc_clip_o = standby[STBY_CDS_AGC_CLIP_BIT]; // RULE5
    assign stby_clamp_blank_o = standby[STBY_CLAMP_BLANK_BIT]; // RULE6
    assign stby_aux_dac_o = standby[STBY_AUX_DAC_BIT]; // RULE7
    assign stby_fixed_amp_o = standby[STBY_FIXED_AMP_BIT]; // RULE8

    // ****************************************************************
    // Checks
    // ****************************************************************
    AST_AUX_LOAD: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // RULE1
        (wr_en && wr_addr == ADDR_AUX_DAC) |=> aux_control_dac_o == $past(wr_data[7:0]))
        else $error("aux DAC code not loaded");

    AST_CLIP_LOAD: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // RULE2
        (wr_en && wr_addr == ADDR_SOFT_CLIP) |=> soft_clip_setting_o == $past(wr_data[3:0]))
        else $error("soft clip setting not loaded");

    AST_GAIN_LOAD: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // RULE3
        (wr_en && wr_addr == ADDR_GAIN) |=> gain_code_o == $past(wr_data[8:0]))
        else $error("gain code not loaded");

    AST_STBY_LOAD: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // RULE4
        (wr_en && wr_addr == ADDR_STANDBY) |=> standby == $past(wr_data[3:0]))
        else $error("standby bits not loaded");

    AST_STBY_CDS: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // RULE5
        (wr_en && wr_addr == ADDR_STANDBY && wr_data[0]) |=> stby_cds_agc_clip_o)
        else $error("sampling stages not in standby");

    AST_STBY_CLAMP: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // RULE6
        (wr_en && wr_addr == ADDR_STANDBY) |=> stby_clamp_blank_o == $past(wr_data[1]))
        else $error("clamp stage standby wrong");

    AST_STBY_AUX: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // RULE7
        (wr_en && wr_addr == ADDR_STANDBY) |=> stby_aux_dac_o == $past(wr_data[2]))
        else $error("aux DAC standby wrong");

    AST_STBY_AMP: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // RULE8
        (wr_en && wr_addr == ADDR_STANDBY && !wr_data[3]) |=> !stby_fixed_amp_o)
        else $error("fixed amplifier standby wrong");

    AST_CLAMP_LOAD: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // RULE9
        (wr_en && wr_addr == ADDR_CLAMP_REF) |=> clamp_ref_dac_code_o == $past(wr_data))
        else $error("clamp reference code not loaded");

    AST_GAIN_SAT: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // RULE12
        gain_applied_o == ((gain_code_o >= 9'h13f) ? 9'h13f : gain_code_o))
        else $error("applied gain not saturated at 319");

    AST_BAD_FRAME: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // RULE13
        (frame_end && bit_cnt != 4'hd) |=> $stable(gain_code_o) && $stable(standby)
            && $stable(clamp_ref_dac_code_o) && $stable(aux_control_dac_o))
        else $error("short or long frame changed a word");

    AST_SHIFT_IN: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // RULE13
        (sen_s && sclk_rise) |=> shreg[0] == $past(sdata_s) && shreg[12:1] == $past(shreg[11:0]))
        else $error("serial bit not shifted in");

    AST_IDLE_HOLD: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // RULE13
        !wr_en |=> $stable(soft_clip_setting_o) && $stable(gain_applied_o))
        else $error("word changed without a write");

endmodule // cfsc_regs

/* cfsc_ctrl_model.sv */
// Camera controller model that loads control words over the 3-wire serial link.
module cfsc_ctrl_model (
    input wire logic sys_clk_i,
    output logic sclk_o,
    output logic sen_o,
    output logic sdata_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // Serial clock stands low outside frames
    initial begin
        sclk_o = 1'b0;
        sen_o = 1'b0;
        sdata_o = 1'b0;
    end

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask

    // ****************************************************************
    // Frame writer
    // ****************************************************************
    // Shifts the first nb bits of {address, data}, MSB first; nb other than 13 makes a bad frame
    task automatic send(input logic [2:0] a, input logic [9:0] d, input int nb);
        logic [12:0] frame;
        frame = {a, d};
        @(posedge sys_clk_i);
        sen_o <= 1'b1;
        for (int i = 12; i > 12 - nb; i--) begin
            wait_cyc(2);
            sdata_o <= frame[i];
            wait_cyc(2);
            // Four cycles low, four high: 200 ns period, the fastest allowed rate
            sclk_o <= 1'b1;
            wait_cyc(4);
            sclk_o <= 1'b0;
        end
        wait_cyc(4);
        sen_o <= 1'b0;
        // Released data line must not keep its last value
        sdata_o <= ~sdata_o;
        wait_cyc(4);
    endtask

endmodule // cfsc_ctrl_model

/* cfsc_regs_tb.sv */
// Self-checking bench for the serially loaded control word bank.
module cfsc_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import cfsc_pkg::*;

    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    wire logic sclk;
    wire logic sen;
    wire logic sdata;
    logic [7:0] aux;
    logic [3:0] clip;
    logic [8:0] gain;
    logic [8:0] gapp;
    logic [3:0] stby;
    logic [9:0] clamp;
    logic [7:0] exp_aux;
    logic [3:0] exp_clip;
    logic [8:0] exp_gain;
    logic [3:0] exp_stby;
    logic [9:0] exp_clamp;
    logic [9:0] gtab [5] = '{10'h000, 10'h13e, 10'h13f, 10'h140, 10'h3ff};
    logic [3:0] stab [6] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'hf, 4'h0};
    int error_cnt = 0;
    int samples_checked = 0;
    int cyc = 0;

    always #12.5 sys_clk = ~sys_clk;

    cfsc_regs i_cfsc_regs (
        .sys_clk_i(sys_clk),
        .rstn_i(rst_n),
        .sclk_i(sclk),
        .sen_i(sen),
        .sdata_i(sdata),
        .aux_control_dac_o(aux),
        .soft_clip_setting_o(clip),
        .gain_code_o(gain),
        .gain_applied_o(gapp),
        .stby_cds_agc_clip_o(stby[0]),
        .stby_clamp_blank_o(stby[1]),
        .stby_aux_dac_o(stby[2]),
        .stby_fixed_amp_o(stby[3]),
        .clamp_ref_dac_code_o(clamp)
    );

    cfsc_ctrl_model i_cfsc_ctrl_model (
        .sys_clk_i(sys_clk),
        .sclk_o(sclk),
        .sen_o(sen),
        .sdata_o(sdata)
    );

    // ****************************************************************
    // Checking and reporting
    // ****************************************************************
    task automatic chk(input string name, input logic [9:0] exp, input logic [9:0] got);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Every word is compared each time, so a write that leaks into another word shows up
    task automatic check_all();
        chk("aux_control_dac", {2'h0, exp_aux}, {2'h0, aux});
        chk("soft_clip_setting", {6'h00, exp_clip}, {6'h00, clip});
        chk("gain_code", {1'b0, exp_gain}, {1'b0, gain});
        chk("gain_applied", {1'b0, (exp_gain >= GAIN_SAT_CODE) ? GAIN_SAT_CODE : exp_gain}, {1'b0, gapp});
        chk("standby", {6'h00, exp_stby}, {6'h00, stby});
        chk("clamp_ref_dac_code", exp_clamp, clamp);
    endtask

    // Output answers 3 cycles after the enable falls; the model already waited 4
    task automatic settle_check();
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        check_all();
    endtask

    task automatic wr(input logic [2:0] a, input logic [9:0] d);
        i_cfsc_ctrl_model.send(a, d, 13);
        settle_check();
    endtask

    task automatic clear_exp();
        exp_aux = RST_AUX_DAC;
        exp_clip = RST_SOFT_CLIP;
        exp_gain = RST_GAIN;
        exp_stby = RST_STANDBY;
        exp_clamp = RST_CLAMP_REF;
    endtask

    // A hang is cut short well beyond the roughly 2100 cycles the tests need
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 8000) begin
            chk("timeout", 10'h000, 10'h001);
            complete_run();
        end
    end

    // ****************************************************************
    // Test sequence
    // ****************************************************************
    initial begin
        clear_exp();
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(negedge sys_clk);
        check_all();
        exp_aux = 8'ha5;
        wr(ADDR_AUX_DAC, 10'h3a5);
        exp_clip = 4'h9;
        wr(ADDR_SOFT_CLIP, 10'h009);
        foreach (gtab[i]) begin
            exp_gain = gtab[i][8:0];
            wr(ADDR_GAIN, gtab[i]);
        end
        foreach (stab[i]) begin
            exp_stby = stab[i];
            wr(ADDR_STANDBY, {6'h00, stab[i]});
        end
        exp_clamp = 10'h2b7;
        wr(ADDR_CLAMP_REF, 10'h2b7);
        // Short frame and an unused address both leave every word untouched
        i_cfsc_ctrl_model.send(ADDR_CLAMP_REF, 10'h155, 12);
        settle_check();
        i_cfsc_ctrl_model.send(3'h5, 10'h3ff, 13);
        settle_check();
        exp_aux = 8'h5a;
        wr(ADDR_AUX_DAC, 10'h05a);
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        clear_exp();
        @(negedge sys_clk);
        check_all();
        // The bank must still load words after a reset in mid-run
        exp_gain = 9'h155;
        wr(ADDR_GAIN, 10'h155);
        complete_run();
    end

endmodule // cfsc_regs_tb
